// ### rtl/cfg_loader_pkg.sv
// Shared constants for the configuration word loader
package cfg_loader_pkg;
  localparam int NUM_WORDS = 9;
  localparam int WORD_W = 24;
  localparam int FLASH_AW = 24;
  // Flash word addresses, largest memory variant
  localparam logic [23:0] ADDR_SEC = 24'h02af00;
  localparam logic [23:0] ADDR_BOOT_SEGMENT_LIMIT = 24'h02af10;
  localparam logic [23:0] ADDR_SIGN = 24'h02af14;
  localparam logic [23:0] ADDR_OSCSEL = 24'h02af18;
  localparam logic [23:0] ADDR_OSC = 24'h02af1c;
  localparam logic [23:0] ADDR_WDT = 24'h02af20;
  localparam logic [23:0] ADDR_POR = 24'h02af24;
  localparam logic [23:0] ADDR_ICD = 24'h02af28;
  localparam logic [23:0] ADDR_DEVOPT = 24'h02af2c;
  // Config page base address for each memory variant
  localparam logic [23:0] BASE_256K = 24'h02af00;
  localparam logic [23:0] BASE_128K = 24'h015f00;
  localparam logic [23:0] BASE_64K = 24'h00af00;
  localparam logic [1:0] VAR_256K = 2'h0;
  localparam logic [1:0] VAR_128K = 2'h1;
  localparam logic [1:0] VAR_64K = 2'h2;
  // Word indices
  localparam logic [3:0] IDX_SEC = 4'h0;
  localparam logic [3:0] IDX_BOOT_SEGMENT_LIMIT = 4'h1;
  localparam logic [3:0] IDX_SIGN = 4'h2;
  localparam logic [3:0] IDX_OSCSEL = 4'h3;
  localparam logic [3:0] IDX_OSC = 4'h4;
  localparam logic [3:0] IDX_WDT = 4'h5;
  localparam logic [3:0] IDX_POR = 4'h6;
  localparam logic [3:0] IDX_ICD = 4'h7;
  localparam logic [3:0] IDX_DEVOPT = 4'h8;
  // Implemented-bit masks; others read as one
  localparam logic [23:0] MASK_SEC = 24'h008fef;
  localparam logic [23:0] MASK_BOOT_SEGMENT_LIMIT = 24'h001fff;
  localparam logic [23:0] MASK_SIGN = 24'h008000;
  localparam logic [23:0] MASK_OSCSEL = 24'h0003ff;
  localparam logic [23:0] MASK_OSC = 24'h0000ff;
  localparam logic [23:0] MASK_WDT = 24'h006bff;
  localparam logic [23:0] MASK_POR = 24'h00000f;
  localparam logic [23:0] MASK_ICD = 24'h0000a3;
  localparam logic [23:0] MASK_DEVOPT = 24'h00001e;
  localparam logic [23:0] ERASED_WORD = 24'hffffff;
  // Field positions
  localparam int SEC_ALT_VECTOR_TABLE_DISABLE_BIT = 15;
  localparam int SEC_CSS_LSB = 9;
  localparam int SEC_CWRP_BIT = 8;
  localparam int SEC_GSS_LSB = 6;
  localparam int SEC_GWRP_BIT = 5;
  localparam int SEC_BSEN_BIT = 3;
  localparam int SEC_BSS_LSB = 1;
  localparam int SEC_BWRP_BIT = 0;
  localparam int BOOT_SEGMENT_LIMIT_W = 13;
  localparam int OSCSEL_TWO_SPEED_STARTUP_BIT = 7;
  localparam int OSCSEL_PLL_LSB = 3;
  localparam int OSCSEL_NOSC_LSB = 0;
  localparam int OSC_CKSM_LSB = 6;
  localparam int OSC_POSC_LSB = 0;
  // Multiplier and oscillator source codes
  localparam logic [3:0] PLL_NONE = 4'hf;
  localparam logic [3:0] PLL_X8 = 4'he;
  localparam logic [3:0] PLL_X6 = 4'hd;
  localparam logic [3:0] PLL_X4 = 4'hc;
  localparam logic [2:0] NOSC_FRC = 3'h0;
  localparam logic [2:0] NOSC_RSVD = 3'h6;
  // APB register map (word per config register)
  localparam logic [7:0] REG_STATUS = 8'h40;
  localparam logic [7:0] REG_RELOAD = 8'h44;
  localparam logic [7:0] REG_DECODE = 8'h48;
  localparam int FLASH_LAT = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } load_state_t;
endpackage

// ### rtl/cfg_word_fetch.sv
// Sequencer that walks the flash configuration word addresses
`timescale 1ns/1ns
module cfg_word_fetch
  import cfg_loader_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [1:0] variant,
  output logic [23:0] flash_addr,
  output logic flash_rd,
  input wire logic flash_valid,
  output logic [3:0] word_idx,
  output logic word_strobe,
  output logic busy
);
  load_state_t state_r, state_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [23:0] base;
  logic [23:0] offs;

  function automatic logic [23:0] word_offset(input logic [3:0] i);
    case (i)
      IDX_SEC: word_offset = ADDR_SEC - BASE_256K;
      IDX_BOOT_SEGMENT_LIMIT: word_offset = ADDR_BOOT_SEGMENT_LIMIT - BASE_256K;
      IDX_SIGN: word_offset = ADDR_SIGN - BASE_256K;
      IDX_OSCSEL: word_offset = ADDR_OSCSEL - BASE_256K;
      IDX_OSC: word_offset = ADDR_OSC - BASE_256K;
      IDX_WDT: word_offset = ADDR_WDT - BASE_256K;
      IDX_POR: word_offset = ADDR_POR - BASE_256K;
      IDX_ICD: word_offset = ADDR_ICD - BASE_256K;
      default: word_offset = ADDR_DEVOPT - BASE_256K;
    endcase
  endfunction

  assign base = (variant == VAR_128K) ? BASE_128K :
                (variant == VAR_64K) ? BASE_64K : BASE_256K;
  assign offs = word_offset(idx_r);
  assign flash_addr = base + offs;
  assign flash_rd = (state_r == ST_REQ);
  assign word_strobe = (state_r == ST_WAIT) && flash_valid;
  assign word_idx = idx_r;
  assign busy = (state_r != ST_IDLE) && (state_r != ST_DONE);

  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start)
        begin
          idx_nxt = 4'h0;
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: state_nxt = ST_WAIT;
      ST_WAIT:
      begin
        if (flash_valid)
        begin
          if (idx_r == 4'(NUM_WORDS - 1))
            state_nxt = ST_DONE;
          else
          begin
            idx_nxt = idx_r + 4'h1;
            state_nxt = ST_REQ;
          end
        end
      end
      ST_DONE:
      begin
        if (start)
        begin
          idx_nxt = 4'h0;
          state_nxt = ST_REQ;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      idx_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
    end
  end
endmodule // cfg_word_fetch

// ### rtl/boot_limit_decode.sv
// Decodes the inverted boot segment limit field
`timescale 1ns/1ns
module boot_limit_decode
  import cfg_loader_pkg::*;
(
  input wire logic [BOOT_SEGMENT_LIMIT_W-1:0] limit_field,
  output logic [BOOT_SEGMENT_LIMIT_W-1:0] first_gs_page,
  output logic boot_seg_present
);
  assign first_gs_page = ~limit_field;
  assign boot_seg_present = (limit_field != {BOOT_SEGMENT_LIMIT_W{1'b1}});
endmodule // boot_limit_decode

// ### rtl/config_word_loader.sv
// Configuration word loader: flash fetch, volatile registers, APB view
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module config_word_loader
  import cfg_loader_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_reset_req,
  input wire logic [1:0] variant,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [23:0] flash_addr,
  output logic flash_rd,
  input wire logic [23:0] flash_data,
  input wire logic flash_valid,
  input wire logic [23:0] prog_addr,
  input wire logic prog_read,
  input wire logic prog_write,
  output logic prog_read_block,
  output logic prog_write_block,
  output logic config_ready,
  output logic dep_reset_n,
  output logic alt_vector_table_disable,
  output logic alt_vector_table_runtime_enable_avail,
  output logic two_speed_startup,
  output logic [2:0] start_osc_select,
  output logic [3:0] freq_multiplier_select,
  output logic pll_runtime_enable_avail,
  output logic pll_mult_en,
  output logic [3:0] pll_mult_factor,
  output logic pll_96mhz_mode,
  output logic [2:0] initial_osc_select,
  output logic clock_switch_en,
  output logic fail_safe_monitor_en,
  output logic [1:0] primary_osc_mode,
  output logic primary_osc_disabled,
  output logic [12:0] boot_segment_limit,
  output logic boot_segment_present,
  output logic [23:0] watchdog_config_word,
  output logic [23:0] power_on_config_word,
  output logic [23:0] debug_config_word,
  output logic [23:0] device_options_word
);

  // ****************************************
  // Reset sync and reload trigger
  // ****************************************
  logic rst_s1_r, rst_s2_r, rst_seen_r;
  logic sw_reload_r;
  logic start;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= sys_reset_req;
      rst_s2_r <= rst_s1_r;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_seen_r <= 1'b1;
    else
      rst_seen_r <= rst_s2_r;
  end
  assign start = rst_seen_r && !rst_s2_r || sw_reload_r;

  // ****************************************
  // Flash word fetch
  // ****************************************
  logic [3:0] word_idx;
  logic word_strobe;
  logic busy;
  cfg_word_fetch u_fetch (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .variant(variant),
    .flash_addr(flash_addr),
    .flash_rd(flash_rd),
    .flash_valid(flash_valid),
    .word_idx(word_idx),
    .word_strobe(word_strobe),
    .busy(busy)
  );

  // ****************************************
  // Volatile configuration registers
  // ****************************************
  function automatic logic [23:0] impl_mask(input logic [3:0] i);
    case (i)
      IDX_SEC: impl_mask = MASK_SEC;
      IDX_BOOT_SEGMENT_LIMIT: impl_mask = MASK_BOOT_SEGMENT_LIMIT;
      IDX_SIGN: impl_mask = MASK_SIGN;
      IDX_OSCSEL: impl_mask = MASK_OSCSEL;
      IDX_OSC: impl_mask = MASK_OSC;
      IDX_WDT: impl_mask = MASK_WDT;
      IDX_POR: impl_mask = MASK_POR;
      IDX_ICD: impl_mask = MASK_ICD;
      default: impl_mask = MASK_DEVOPT;
    endcase
  endfunction

  logic [23:0] cfg_r [NUM_WORDS];
  logic [23:0] masked_word;
  // upper byte ignored, unimplemented bits forced high
  assign masked_word = (flash_data & impl_mask(word_idx)) | ~impl_mask(word_idx);

  logic [NUM_WORDS-1:0] word_load;
  genvar g;
  generate
    for (g = 0; g < NUM_WORDS; g++)
    begin : g_cfg
      // One load enable per word slot
      assign word_load[g] = word_strobe && (word_idx == 4'(g));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cfg_r[g] <= ERASED_WORD;
        else if (word_load[g])
          cfg_r[g] <= masked_word;
      end
    end
  endgenerate

  // ****************************************
  // Load sequencing
  // ****************************************
  // hold dependents in reset
  logic loaded_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loaded_r <= 1'b0;
    // A pending reset request withdraws the settings at once
    else if (start || rst_s2_r)
      loaded_r <= 1'b0;
    else if (word_load[NUM_WORDS - 1])
      loaded_r <= 1'b1;
  end
  assign config_ready = loaded_r;
  assign dep_reset_n = loaded_r && !busy;

  // ****************************************
  // Field decode
  // ****************************************
  logic [23:0] sec_w, oscsel_w, osc_w;
  assign sec_w = cfg_r[IDX_SEC];
  assign oscsel_w = cfg_r[IDX_OSCSEL];
  assign osc_w = cfg_r[IDX_OSC];

  assign alt_vector_table_disable = sec_w[SEC_ALT_VECTOR_TABLE_DISABLE_BIT];
  assign alt_vector_table_runtime_enable_avail = !sec_w[SEC_ALT_VECTOR_TABLE_DISABLE_BIT];

  // ****************************************
  // Boot segment limit
  // ****************************************
  // first general segment page
  boot_limit_decode u_boot_segment_limit (
    .limit_field(cfg_r[IDX_BOOT_SEGMENT_LIMIT][BOOT_SEGMENT_LIMIT_W-1:0]),
    .first_gs_page(boot_segment_limit),
    .boot_seg_present(boot_segment_present)
  );

  // ****************************************
  // Clock source decode
  // ****************************************
  // two-speed start-up
  assign two_speed_startup = oscsel_w[OSCSEL_TWO_SPEED_STARTUP_BIT];
  assign initial_osc_select = oscsel_w[OSCSEL_NOSC_LSB +: 3];
  assign start_osc_select = two_speed_startup ? NOSC_FRC : initial_osc_select;

  // ****************************************
  // Multiplier decode
  // ****************************************
  // multiplier decode
  logic mult_none, mult_x8, mult_x6, mult_x4;
  assign freq_multiplier_select = oscsel_w[OSCSEL_PLL_LSB +: 4];
  assign mult_none = (freq_multiplier_select == PLL_NONE);
  assign mult_x8 = (freq_multiplier_select == PLL_X8);
  assign mult_x6 = (freq_multiplier_select == PLL_X6);
  assign mult_x4 = (freq_multiplier_select == PLL_X4);
  assign pll_runtime_enable_avail = !mult_none;
  assign pll_96mhz_mode = !freq_multiplier_select[3] && (freq_multiplier_select != 4'h0);
  // Unlisted codes leave the fixed multiplier off
  assign pll_mult_factor = mult_x8 ? 4'h8 :
                           mult_x6 ? 4'h6 :
                           mult_x4 ? 4'h4 : 4'h0;
  assign pll_mult_en = pll_96mhz_mode || (pll_mult_factor != 4'h0);

  // reserved source code kept visible via select; relies on image

  // ****************************************
  // Oscillator word decode
  // ****************************************
  // clock switch and monitor
  logic [1:0] cksm_field;
  assign cksm_field = osc_w[OSC_CKSM_LSB +: 2];
  // Upper bit set turns both off whatever the lower bit says
  assign clock_switch_en = !cksm_field[1];
  assign fail_safe_monitor_en = (cksm_field == 2'b00);
  assign primary_osc_mode = osc_w[OSC_POSC_LSB +: 2];
  assign primary_osc_disabled = (primary_osc_mode == 2'b11);


  // ****************************************
  // Raw word outputs
  // ****************************************
  assign watchdog_config_word = cfg_r[IDX_WDT];
  assign power_on_config_word = cfg_r[IDX_POR];
  assign debug_config_word = cfg_r[IDX_ICD];
  assign device_options_word = cfg_r[IDX_DEVOPT];

  // ****************************************
  // Code protection
  // ****************************************
  function automatic logic seg_open(input logic [1:0] lvl);
    seg_open = (lvl == 2'b11);
  endfunction

  logic in_boot, in_cfg_page;
  logic bs_open, gs_open, cfg_open;
  logic bs_prot_rd, gs_prot_rd, cfg_prot_rd;
  logic bs_prot_wr, gs_prot_wr, cfg_prot_wr;
  logic rd_denied, wr_denied;
  logic [12:0] prog_page;
  logic [23:0] cfg_base;
  assign prog_page = prog_addr[23:11];
  assign cfg_base = (variant == VAR_128K) ? BASE_128K :
                    (variant == VAR_64K) ? BASE_64K : BASE_256K;
  // Boot region ends below the first general segment page
  assign in_boot = boot_segment_present && (prog_page < boot_segment_limit);
  assign in_cfg_page = (prog_addr[23:8] == cfg_base[23:8]);

  // All ones is the only open security level
  assign bs_open = seg_open(sec_w[SEC_BSS_LSB +: 2]);
  assign gs_open = seg_open(sec_w[SEC_GSS_LSB +: 2]);
  assign cfg_open = (sec_w[SEC_CSS_LSB +: 3] == 3'b111);
  assign bs_prot_rd = !bs_open;
  assign gs_prot_rd = !gs_open;
  assign cfg_prot_rd = !cfg_open;
  // Write protect bit low locks a segment even when open
  assign bs_prot_wr = !sec_w[SEC_BWRP_BIT] || !bs_open;
  assign gs_prot_wr = !sec_w[SEC_GWRP_BIT] || !gs_open;
  assign cfg_prot_wr = !sec_w[SEC_CWRP_BIT];

  // Region select
  assign rd_denied = in_boot ? bs_prot_rd : in_cfg_page ? cfg_prot_rd : gs_prot_rd;
  assign wr_denied = in_boot ? bs_prot_wr : in_cfg_page ? cfg_prot_wr : gs_prot_wr;

  // block protected access
  // Nothing is trusted until the last configuration word is loaded
  assign prog_write_block = prog_write && (!loaded_r || wr_denied);
  assign prog_read_block = prog_read && (!loaded_r || rd_denied);

  // ****************************************
  // APB slave
  // ****************************************
  logic wr_en, rd_en, addr_cfg, addr_ok;
  logic addr_status, addr_reload, addr_decode, bad_write;
  logic [3:0] rd_idx;
  logic [31:0] rd_val, status_val, decode_val, cfg_val;
  // Zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  // Read data captured in setup, held through access
  assign rd_en = psel && !penable && !pwrite;
  assign rd_idx = paddr[5:2];
  assign addr_cfg = (paddr[11:6] == 6'h00) && (rd_idx < 4'(NUM_WORDS)) && (paddr[1:0] == 2'h0);
  assign addr_status = (paddr[7:0] == REG_STATUS);
  assign addr_reload = (paddr[7:0] == REG_RELOAD);
  assign addr_decode = (paddr[7:0] == REG_DECODE);
  assign addr_ok = addr_cfg || addr_status || addr_reload || addr_decode;
  // Only the reload register takes writes
  assign bad_write = pwrite && !addr_reload;
  assign pslverr = psel && penable && (!addr_ok || bad_write);

  // ****************************************
  // Read data select
  // ****************************************
  assign cfg_val = {8'h00, cfg_r[rd_idx]};
  assign status_val = {30'h0, busy, loaded_r};
  assign decode_val = {16'h0, boot_segment_present, boot_segment_limit,
                       alt_vector_table_disable, pll_runtime_enable_avail};
  assign rd_val = addr_cfg ? cfg_val :
                  addr_status ? status_val :
                  addr_decode ? decode_val : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_en)
      prdata <= rd_val;
  end

  // ****************************************
  // Software reload strobe
  // ****************************************
  logic reload_hit;
  assign reload_hit = wr_en && (paddr[11:0] == {4'h0, REG_RELOAD}) && pwdata[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_reload_r <= 1'b0;
    else
      sw_reload_r <= reload_hit;
  end
endmodule // config_word_loader

// ### tb/flash_model.sv
// Behavioural program flash that answers configuration word reads
`timescale 1ns/1ns
module flash_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [23:0] flash_addr,
  input wire logic flash_rd,
  output logic [23:0] flash_data,
  output logic flash_valid
);
  // ********
  // Read path
  // ********
  logic [23:0] mem [logic [23:0]];
  logic [23:0] addr_r;
  logic [3:0] wait_r;
  logic busy_r;
  logic fire;
  assign fire = busy_r && wait_r == 4'h0 && !flash_rd;
  // Idle data lines toggle so a stale word never passes for an answer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      flash_valid <= 1'b0;
      flash_data <= 24'h5a5a5a;
    end
    else
    begin
      flash_valid <= fire;
      flash_data <= fire ? (mem.exists(addr_r) ? mem[addr_r] : 24'h000000) : ~flash_data;
      if (flash_rd)
      begin
        busy_r <= 1'b1;
        addr_r <= flash_addr;
        wait_r <= slow ? 4'h6 : 4'h0;
      end
      else if (fire)
        busy_r <= 1'b0;
      else if (busy_r)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule // flash_model

// ### tb/cfg_loader_asserts.sv
// Port-level assertions for the configuration word loader
`timescale 1ns/1ns
module cfg_loader_asserts
  import cfg_loader_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] variant,
  input wire logic [23:0] flash_addr,
  input wire logic flash_rd,
  input wire logic flash_valid,
  input wire logic config_ready,
  input wire logic dep_reset_n,
  input wire logic two_speed_startup,
  input wire logic [2:0] start_osc_select,
  input wire logic [2:0] initial_osc_select,
  input wire logic [3:0] freq_multiplier_select,
  input wire logic pll_runtime_enable_avail,
  input wire logic [12:0] boot_segment_limit,
  input wire logic boot_segment_present
);
  // ********
  // Checks
  // ********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [23:0] page_base;
  assign page_base = (variant == VAR_128K) ? BASE_128K : (variant == VAR_64K) ? BASE_64K : BASE_256K;
  sequence s_hold;
    ##1 !flash_rd && $stable(flash_addr);
  endsequence
  sequence s_next;
    ##[1:2] flash_rd || config_ready;
  endsequence
  property p_rd_pulse;
    flash_rd |-> s_hold;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe not held right");
  property p_page;
    flash_rd |-> (flash_addr - page_base) <= 24'h00002c && flash_addr[1:0] == 2'b00;
  endproperty
  a_page: assert property (p_page) else $error("read outside config page");
  property p_step;
    flash_valid && !config_ready |-> s_next;
  endproperty
  a_step: assert property (p_step) else $error("load stalled after word");
  property p_ready_rise;
    $rose(config_ready) |-> $past(flash_valid) || $past(flash_valid, 2);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready without last word");
  property p_dep_hold;
    !config_ready |-> !dep_reset_n;
  endproperty
  a_dep_hold: assert property (p_dep_hold) else $error("dependents released early");
  property p_two_speed;
    start_osc_select == (two_speed_startup ? NOSC_FRC : initial_osc_select);
  endproperty
  a_two_speed: assert property (p_two_speed) else $error("start source wrong");
  property p_pll;
    pll_runtime_enable_avail == (freq_multiplier_select != PLL_NONE);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable availability wrong");
  property p_boot_segment_limit;
    boot_segment_present == (boot_segment_limit != 13'h0000);
  endproperty
  a_boot_segment_limit: assert property (p_boot_segment_limit) else $error("boot segment presence wrong");
endmodule // cfg_loader_asserts
bind config_word_loader cfg_loader_asserts u_chk (.*);

// ### tb/testbench.sv
// Self-checking bench for the configuration word loader
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin $display("[ERR] %s exp %h got %h", nm, e, g); err_count++; end end
module testbench import cfg_loader_pkg::*;;
  // ********
  // Stimulus
  // ********
  int err_count = 0;
  int n_checks = 0;
  logic pclk = 1'b0, presetn = 1'b0, sys_reset_req = 1'b0, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prog_read = 1'b1, prog_write = 1'b1;
  logic [1:0] variant = VAR_256K;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] prog_addr = 24'h002000;
  logic [31:0] prdata, rd_q;
  logic [23:0] flash_addr, flash_data, watchdog_config_word, power_on_config_word;
  logic [23:0] debug_config_word, device_options_word;
  logic pready, pslverr, err_q, flash_rd, flash_valid, prog_read_block, prog_write_block;
  logic config_ready, dep_reset_n, alt_vector_table_disable, alt_vector_table_runtime_enable_avail;
  logic two_speed_startup, pll_runtime_enable_avail, pll_mult_en, pll_96mhz_mode;
  logic clock_switch_en, fail_safe_monitor_en, primary_osc_disabled, boot_segment_present;
  logic [2:0] start_osc_select, initial_osc_select;
  logic [3:0] freq_multiplier_select, pll_mult_factor;
  logic [1:0] primary_osc_mode;
  logic [12:0] boot_segment_limit;
  // upper bytes zero, a few unimplemented bits set
  logic [23:0] im [2][9] = '{'{24'h000fff, 24'h001fff, 24'h000000, 24'h0000f3, 24'h00003e,
    24'h001234, 24'h000005, 24'h000021, 24'h000008}, '{24'h008f1f, 24'h001ffc, 24'h000000,
    24'h00002d, 24'h00007f, 24'h000000, 24'h000000, 24'h000000, 24'h000000}};
  logic [23:0] mk [9] = '{MASK_SEC, MASK_BOOT_SEGMENT_LIMIT, MASK_SIGN, MASK_OSCSEL, MASK_OSC, MASK_WDT,
    MASK_POR, MASK_ICD, MASK_DEVOPT};
  logic [23:0] wa [9] = '{ADDR_SEC, ADDR_BOOT_SEGMENT_LIMIT, ADDR_SIGN, ADDR_OSCSEL, ADDR_OSC, ADDR_WDT,
    ADDR_POR, ADDR_ICD, ADDR_DEVOPT};
  config_word_loader dut (.*);
  flash_model fm (.*);
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  function automatic logic [23:0] base_of(input logic [1:0] v);
    return (v == VAR_128K) ? BASE_128K : (v == VAR_64K) ? BASE_64K : BASE_256K;
  endfunction
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (n >= 64) err_count++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check_all(input int k);
    logic [23:0] s, b, o, c;
    logic [3:0] m, f;
    s = im[k][0];
    b = im[k][1];
    o = im[k][3];
    c = im[k][4];
    m = o[6:3];
    f = (m == PLL_X8) ? 4'h8 : (m == PLL_X6) ? 4'h6 : (m == PLL_X4) ? 4'h4 : 4'h0;
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      apb(12'(4 * i), 1'b0, 32'h0);
      `CHK("cfg_word", {8'h00, im[k][i] | ~mk[i]}, rd_q)
    end
    `CHK("alternate_vector_table", {s[15], ~s[15]},
      {alt_vector_table_disable, alt_vector_table_runtime_enable_avail})
    `CHK("init_osc", {o[7], o[2:0]}, {two_speed_startup, initial_osc_select})
    `CHK("start_osc", o[7] ? NOSC_FRC : o[2:0], start_osc_select)
    `CHK("pll_code", {m, f, m inside {[4'h1:4'h7]}, (m inside {[4'h1:4'h7]}) || f != 4'h0},
      {freq_multiplier_select, pll_mult_factor, pll_96mhz_mode, pll_mult_en})
    `CHK("clk_sw", {~c[7], c[7:6] == 2'b00}, {clock_switch_en, fail_safe_monitor_en})
    `CHK("posc", {c[1:0], c[1:0] == 2'b11}, {primary_osc_mode, primary_osc_disabled})
    `CHK("boot_segment_limit", {~b[12:0], b[12:0] != 13'h1fff},
      {boot_segment_limit, boot_segment_present})
    `CHK("wdt", im[k][5] | ~mk[5], watchdog_config_word)
    `CHK("raw", {im[k][6] | ~mk[6], im[k][7] | ~mk[7], im[k][8] | ~mk[8]},
      {power_on_config_word, debug_config_word, device_options_word})
    `CHK("prot", {s[7:6] != 2'b11, s[7:6] != 2'b11 || !s[5]},
      {prog_read_block, prog_write_block})
  endtask
  task automatic reload(input int k, input logic [1:0] v, input logic sl, input int how);
    int n;
    for (int i = 0; i < NUM_WORDS; i++)
      fm.mem[base_of(v) + wa[i] - BASE_256K] = im[k][i];
    @(posedge pclk);
    slow <= sl;
    if (how == 0)
    begin
      presetn <= 1'b0;
      variant <= v;
      @(posedge pclk);
      `CHK("in_reset", 2'b00, {config_ready, dep_reset_n})
      repeat (15) @(posedge pclk);
      presetn <= 1'b1;
    end
    else if (how == 1)
    begin
      sys_reset_req <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK("req_hold", 2'b00, {config_ready, dep_reset_n})
      sys_reset_req <= 1'b0;
    end
    else
      apb({4'h0, REG_RELOAD}, 1'b1, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK("loading", 3'b001, {config_ready, dep_reset_n, prog_read_block})
    n = 0;
    while (config_ready !== 1'b1 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("ready", 2'b11, {config_ready, dep_reset_n})
    check_all(k);
  endtask
  task automatic t_apb_err();
    apb(12'h004, 1'b1, 32'h0);
    `CHK("wr_err", 1'b1, err_q)
    apb(12'h004, 1'b0, 32'h0);
    `CHK("wr_keep", {8'h00, im[0][1] | ~mk[1]}, rd_q)
    apb(12'h03c, 1'b0, 32'h0);
    `CHK("gap_err", 1'b1, err_q)
    apb({4'h0, REG_STATUS}, 1'b0, 32'h0);
    `CHK("status", 32'h1, rd_q)
    apb({4'h0, REG_DECODE}, 1'b0, 32'h0);
    `CHK("decode", 32'h1, rd_q)
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    reload(0, VAR_256K, 1'b0, 0);
    t_apb_err();
    reload(1, VAR_256K, 1'b1, 1);
    apb({4'h0, REG_RELOAD}, 1'b1, 32'h1);
    repeat (5) @(posedge pclk);
    reload(0, VAR_64K, 1'b0, 0);
    reload(1, VAR_64K, 1'b1, 2);
    reload(1, VAR_128K, 1'b0, 0);
    complete_run();
  end
  initial
  begin
    #(50 * 20000);
    err_count++;
    complete_run();
  end
endmodule // testbench
